// ===== metirq_bank.sv
// Operation
// - enable bit 17 passes a full waveform page selected for page irqs.
// - enable bit 16 passes the capture buffer stopping after a trigger.
// - with enable bit 15 set, every new waveform sample raises the interrupt.
// - enable bits 11 to 14 pass pulse outputs one to four falling.
// - enable bits 7 to 10 pass a pulse sign change against the last pulse.
// - enable bits 4, 5, 6 pass a reactive power sign change of phase A, B, C.
// - enable bits 1, 2, 3 pass an active power sign change of phase A, B, C.
// - enable bit 0 passes each update of the accumulated energy registers.
// - word b bit 31 passes fault three, cleared only by a soft or hard reset.
// - enable word b bit 30 passes fault two.
// - faults one and zero at bits 29, 28 always interrupt, clear by reset.
// - enable bit 27 passes completion of a forced checksum calculation.
// - enable bit 26 passes a checksum change; the new checksum is held.
// - enable bits 25 and 24 pass phase C and phase B entering a voltage dip.
// - each pulse output's latest sign is recorded as it falls, one positive.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module metirq_bank #(
    parameter int AW = metirq_pkg::ADDR_W
) (
    input  wire logic          CLK_SYS_IN,            // 250 MHz clock
    input  wire logic          RESET_IN,              // async reset, high
    input  wire logic          PSEL_IN,               // apb select
    input  wire logic          PENABLE_IN,            // apb access phase
    input  wire logic          PWRITE_IN,             // apb write
    input  wire logic [AW-1:0] PADDR_IN,              // apb byte address
    input  wire logic [31:0]   PWDATA_IN,             // apb write data
    input  wire logic [3:0]    PSTRB_IN,              // apb byte enables
    output logic      [31:0]   PRDATA_OUT,            // apb read data
    output logic               PREADY_OUT,            // apb ready
    output logic               PSLVERR_OUT,           // apb error
    input  wire logic [15:0]   PAGE_FILLED_IN,        // page full pulses
    input  wire logic          TRIG_STOP_IN,          // capture stopped
    input  wire logic          SAMPLE_READY_IN,       // new samples
    input  wire logic [3:0]    PULSE_OUT_PIN_IN,      // pulse pins 1..4
    input  wire logic [3:0]    PULSE_SIGN_IN,         // energy sign 1..4
    input  wire logic [2:0]    ACTIVE_SIGN_CHG_IN,    // phase a,b,c
    input  wire logic [2:0]    REACTIVE_SIGN_CHG_IN,  // phase a,b,c
    input  wire logic          ENERGY_UPDATE_IN,      // energy update
    input  wire logic [3:0]    FAULT_IN,              // faults 3..0
    input  wire logic          CHECKSUM_DONE_IN,      // forced crc done
    input  wire logic          CHECKSUM_CHANGED_IN,   // crc changed
    input  wire logic [31:0]   CHECKSUM_VALUE_IN,     // new crc value
    input  wire logic [1:0]    SAG_LEVEL_IN,          // dip: [1] c, [0] b
    output logic               IRQ_OUT                // interrupt, high
);
    typedef struct packed {
        logic [31:0] ena_a;
        logic [31:0] ena_b;
        logic [15:0] page_sel;
        logic [31:0] cksum;
        logic [1:0]  sag_prev;
        logic [31:0] rdata;
        logic        slverr;
        logic        soft_clr;
        logic        irq;
    } metirq_bank_t;

    metirq_bank_t st_ff;
    metirq_bank_t nxt_st;

    logic [31:0] ev_a;
    logic [31:0] ev_b;
    logic [31:0] clr_a;
    logic [31:0] clr_b;
    logic [31:0] stat_a;
    logic [31:0] stat_b;
    logic [3:0]  issued;
    logic [3:0]  sign_chg;
    logic [3:0]  sign_rec;
    logic [11:0] widx;
    logic        addr_ok;
    logic        hit;
    logic        setup;
    logic        wr_acc;
    logic [31:0] wmask;
    logic [31:0] pg_merge;

    // decode reads bits 13:2, so a narrower bus cannot reach the map
    if (AW < metirq_pkg::ADDR_W) begin : g_aw_check
        $error("metirq_bank: AW must be at least 14");
    end

    metirq_pulse_mon #(
        .N (metirq_pkg::PULSE_N)
    ) u_pulse (
        .clk_in       (CLK_SYS_IN),
        .rst_in       (RESET_IN),
        .pin_in       (PULSE_OUT_PIN_IN),
        .sign_in      (PULSE_SIGN_IN),
        .issued_out   (issued),
        .sign_chg_out (sign_chg),
        .sign_out     (sign_rec)
    );

    metirq_sticky #(
        .W (32)
    ) u_stat_a (
        .clk_in (CLK_SYS_IN),
        .rst_in (RESET_IN),
        .set_in (ev_a),
        .clr_in (clr_a),
        .q_out  (stat_a)
    );

    metirq_sticky #(
        .W (32)
    ) u_stat_b (
        .clk_in (CLK_SYS_IN),
        .rst_in (RESET_IN),
        .set_in (ev_b),
        .clr_in (clr_b),
        .q_out  (stat_b)
    );

    // event vectors share the bit layout of the enable words
    always_comb begin
        ev_a = metirq_pkg::RST_WORD;
        ev_a[metirq_pkg::BIT_PAGE_FULL] =
            |(PAGE_FILLED_IN & st_ff.page_sel);
        ev_a[metirq_pkg::BIT_TRIG_STOP] = TRIG_STOP_IN;
        ev_a[metirq_pkg::BIT_SAMPLE]    = SAMPLE_READY_IN;
        ev_a[metirq_pkg::BIT_PULSE_LO +: 4] = issued;
        ev_a[metirq_pkg::BIT_SIGN_LO +: 4]  = sign_chg;
        ev_a[metirq_pkg::BIT_REACT_LO +: 3] = REACTIVE_SIGN_CHG_IN;
        ev_a[metirq_pkg::BIT_ACT_LO +: 3]   = ACTIVE_SIGN_CHG_IN;
        ev_a[metirq_pkg::BIT_ENERGY]    = ENERGY_UPDATE_IN;

        ev_b = metirq_pkg::RST_WORD;
        ev_b[metirq_pkg::BIT_FAULT_LO +: 4] = FAULT_IN;
        ev_b[metirq_pkg::BIT_CRC_DONE] = CHECKSUM_DONE_IN;
        ev_b[metirq_pkg::BIT_CHECKSUM_CHANGED_IRQ_EN]  = CHECKSUM_CHANGED_IN;
        // dip entry only, staying in a dip is not a new event
        ev_b[metirq_pkg::BIT_SAG_LO +: 2] =
            SAG_LEVEL_IN & ~st_ff.sag_prev;
    end

    // address decode; misaligned or out of range words are unmapped
    always_comb begin
        widx    = PADDR_IN[13:2];
        addr_ok = (PADDR_IN[1:0] == 2'h0);
        if (AW > metirq_pkg::ADDR_W) begin
            addr_ok = addr_ok && ((PADDR_IN >> metirq_pkg::ADDR_W) == '0);
        end
        case (widx)
            metirq_pkg::IDX_STAT_A,
            metirq_pkg::IDX_STAT_B,
            metirq_pkg::IDX_ENA_A,
            metirq_pkg::IDX_ENA_B,
            metirq_pkg::IDX_SIGN,
            metirq_pkg::IDX_PAGE_SEL,
            metirq_pkg::IDX_CKSUM,
            metirq_pkg::IDX_CTRL: hit = addr_ok;
            default:              hit = 1'b0;
        endcase
        setup  = PSEL_IN && !PENABLE_IN;
        wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && hit;
        wmask  = PWDATA_IN & metirq_pkg::strb_bits(PSTRB_IN);
    end

    // write-one-to-clear; faults 3, 1, 0 clear only by reset
    always_comb begin
        clr_a = metirq_pkg::RST_WORD;
        clr_b = metirq_pkg::RST_WORD;
        if (wr_acc && widx == metirq_pkg::IDX_STAT_A) begin
            clr_a = wmask & metirq_pkg::STAT_A_W1C;
        end
        if (wr_acc && widx == metirq_pkg::IDX_STAT_B) begin
            clr_b = wmask & metirq_pkg::STAT_B_W1C;
        end
        if (st_ff.soft_clr) begin
            clr_b = clr_b | metirq_pkg::FAULT_HELD;
        end
    end

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.sag_prev = SAG_LEVEL_IN;
        nxt_st.soft_clr = 1'b0;
        // page select honours byte enables like the enable words
        pg_merge        = metirq_pkg::merge_strb({16'h0000, st_ff.page_sel},
            PWDATA_IN, PSTRB_IN, 32'h0000ffff);

        if (CHECKSUM_CHANGED_IN || CHECKSUM_DONE_IN) begin
            nxt_st.cksum = CHECKSUM_VALUE_IN;
        end

        if (wr_acc) begin
            case (widx)
                metirq_pkg::IDX_ENA_A: begin
                    nxt_st.ena_a = metirq_pkg::merge_strb(st_ff.ena_a,
                        PWDATA_IN, PSTRB_IN, metirq_pkg::ENA_A_WMASK);
                end
                metirq_pkg::IDX_ENA_B: begin
                    nxt_st.ena_b = metirq_pkg::merge_strb(st_ff.ena_b,
                        PWDATA_IN, PSTRB_IN, metirq_pkg::ENA_B_WMASK);
                end
                metirq_pkg::IDX_PAGE_SEL: begin
                    nxt_st.page_sel = pg_merge[15:0];
                end
                metirq_pkg::IDX_CTRL: begin
                    nxt_st.soft_clr = wmask[metirq_pkg::BIT_SOFT_RST];
                end
                default: begin
                    nxt_st.soft_clr = 1'b0;
                end
            endcase
        end

        // read data captured in the setup cycle, so it leaves a flop
        if (setup) begin
            nxt_st.slverr = !hit;
            case (hit ? widx : 12'h000)
                metirq_pkg::IDX_STAT_A:   nxt_st.rdata = stat_a;
                metirq_pkg::IDX_STAT_B:   nxt_st.rdata = stat_b;
                metirq_pkg::IDX_ENA_A:    nxt_st.rdata = st_ff.ena_a;
                metirq_pkg::IDX_ENA_B:    nxt_st.rdata = st_ff.ena_b;
                metirq_pkg::IDX_SIGN:
                    nxt_st.rdata = {28'h0000000, sign_rec};
                metirq_pkg::IDX_PAGE_SEL:
                    nxt_st.rdata = {16'h0000, st_ff.page_sel};
                metirq_pkg::IDX_CKSUM:    nxt_st.rdata = st_ff.cksum;
                default:                  nxt_st.rdata = metirq_pkg::RST_WORD;
            endcase
        end

        // faults 1 and 0 bypass the enable word
        nxt_st.irq = |(stat_a & st_ff.ena_a)
                   | |(stat_b & st_ff.ena_b & ~metirq_pkg::FAULT_NOMASK)
                   | |(stat_b & metirq_pkg::FAULT_NOMASK);
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // one wait-free access phase after setup
    assign PREADY_OUT  = PSEL_IN && PENABLE_IN;
    assign PRDATA_OUT  = st_ff.rdata;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && st_ff.slverr;
    assign IRQ_OUT     = st_ff.irq;
endmodule : metirq_bank

// ===== metirq_pkg.sv
package metirq_pkg;

    localparam int          ADDR_W        = 14;
    localparam int          DATA_W        = 32;
    localparam int          PAGE_N        = 16;
    localparam int          PULSE_N       = 4;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_STAT_A    = 12'h402;
    localparam logic [11:0] IDX_STAT_B    = 12'h403;
    localparam logic [11:0] IDX_ENA_A     = 12'h405;
    localparam logic [11:0] IDX_ENA_B     = 12'h406;
    localparam logic [11:0] IDX_SIGN      = 12'h410;
    localparam logic [11:0] IDX_PAGE_SEL  = 12'h411;
    localparam logic [11:0] IDX_CKSUM     = 12'h412;
    localparam logic [11:0] IDX_CTRL      = 12'h413;

    // word a bit positions
    localparam int          BIT_PAGE_FULL = 17;
    localparam int          BIT_TRIG_STOP = 16;
    localparam int          BIT_SAMPLE    = 15;
    localparam int          BIT_PULSE_LO  = 11;
    localparam int          BIT_SIGN_LO   = 7;
    localparam int          BIT_REACT_LO  = 4;
    localparam int          BIT_ACT_LO    = 1;
    localparam int          BIT_ENERGY    = 0;
    // word b bit positions, then the soft reset bit of the control word
    localparam int          BIT_FAULT_LO  = 28;
    localparam int          BIT_CRC_DONE  = 27;
    localparam int          BIT_CHECKSUM_CHANGED_IRQ_EN   = 26;
    localparam int          BIT_SAG_LO    = 24;
    localparam int          BIT_SOFT_RST  = 0;

    localparam logic [31:0] ENA_A_WMASK   = 32'h0003ffff;
    localparam logic [31:0] ENA_B_WMASK   = 32'hff000000;
    localparam logic [31:0] STAT_A_W1C    = 32'h0003ffff;
    localparam logic [31:0] STAT_B_W1C    = 32'h4f000000;
    localparam logic [31:0] FAULT_HELD    = 32'hb0000000;
    localparam logic [31:0] FAULT_NOMASK  = 32'h30000000;
    localparam logic [31:0] RST_WORD      = 32'h00000000;

    function automatic logic [31:0] strb_bits(input logic [3:0] strb);
        strb_bits = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : strb_bits

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  strb,
                                               input logic [31:0] wmask);
        logic [31:0] en;
        en         = strb_bits(strb) & wmask;
        merge_strb = (old & ~en) | (wdata & en);
    endfunction : merge_strb

endpackage : metirq_pkg

// ===== metirq_sticky.sv
`timescale 1ns/10ps
module metirq_sticky #(
    parameter int W = 32
) (
    input  wire logic         clk_in,   // system clock
    input  wire logic         rst_in,   // async reset, high
    input  wire logic [W-1:0] set_in,   // event pulses
    input  wire logic [W-1:0] clr_in,   // clear pulses
    output logic      [W-1:0] q_out     // sticky flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } metirq_stk_t;

    metirq_stk_t st_ff;
    metirq_stk_t nxt_st;

    if (W < 1) begin : g_w_check
        $error("metirq_sticky: W must be at least 1");
    end

    always_comb begin
        nxt_st       = st_ff;
        // set after clear, so an event in the clear cycle survives
        nxt_st.flags = (st_ff.flags & ~clr_in) | set_in;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_out = st_ff.flags;
endmodule : metirq_sticky

// ===== metirq_pulse_mon.sv
`timescale 1ns/10ps
module metirq_pulse_mon #(
    parameter int N = 4
) (
    input  wire logic         clk_in,       // system clock
    input  wire logic         rst_in,       // async reset, high
    input  wire logic [N-1:0] pin_in,       // pulse pins, async
    input  wire logic [N-1:0] sign_in,      // energy sign, 1 positive
    output logic      [N-1:0] issued_out,   // falling edge seen, pulse
    output logic      [N-1:0] sign_chg_out, // sign flipped, pulse
    output logic      [N-1:0] sign_out      // sign of latest pulse
);
    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] prev;
        logic [N-1:0] sign;
        logic [N-1:0] seen;
        logic [N-1:0] issued;
        logic [N-1:0] chg;
    } metirq_pm_t;

    metirq_pm_t st_ff;
    metirq_pm_t nxt_st;
    logic [N-1:0] fall;

    if (N < 1) begin : g_n_check
        $error("metirq_pulse_mon: N must be at least 1");
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = pin_in;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev  = st_ff.sync2;
        fall         = st_ff.prev & ~st_ff.sync2;
        nxt_st.issued = fall;
        // no polarity change on the first pulse after reset
        nxt_st.chg   = fall & st_ff.seen & (sign_in ^ st_ff.sign);
        nxt_st.sign  = (st_ff.sign & ~fall) | (sign_in & fall);
        nxt_st.seen  = st_ff.seen | fall;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign issued_out   = st_ff.issued;
    assign sign_chg_out = st_ff.chg;
    assign sign_out     = st_ff.sign;
endmodule : metirq_pulse_mon

// ===== metirq_bank_props.sv
`timescale 1ns/10ps
module metirq_bank_props #(
    parameter int AW = 14
) (
    input wire logic          CLK_SYS_IN,
    input wire logic          RESET_IN,
    input wire logic          PSEL_IN,
    input wire logic          PENABLE_IN,
    input wire logic          PWRITE_IN,
    input wire logic [AW-1:0] PADDR_IN,
    input wire logic [31:0]   PWDATA_IN,
    input wire logic [3:0]    PSTRB_IN,
    input wire logic          PREADY_OUT,
    input wire logic [15:0]   PAGE_FILLED_IN,
    input wire logic          TRIG_STOP_IN,
    input wire logic          SAMPLE_READY_IN,
    input wire logic [3:0]    PULSE_OUT_PIN_IN,
    input wire logic [2:0]    ACTIVE_SIGN_CHG_IN,
    input wire logic [2:0]    REACTIVE_SIGN_CHG_IN,
    input wire logic          ENERGY_UPDATE_IN,
    input wire logic [3:0]    FAULT_IN,
    input wire logic          CHECKSUM_DONE_IN,
    input wire logic          CHECKSUM_CHANGED_IN,
    input wire logic [1:0]    SAG_LEVEL_IN,
    input wire logic          IRQ_OUT
);
    // shadow of the enables, so a mask can be tied to its event
    logic [31:0] ea_ff, eb_ff, sel_ff, bm;
    logic        wr, q;
    assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
    assign q = !PENABLE_IN;
    assign bm = {{8{PSTRB_IN[3]}}, {8{PSTRB_IN[2]}},
                 {8{PSTRB_IN[1]}}, {8{PSTRB_IN[0]}}};
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ea_ff <= '0;
            eb_ff <= '0;
            sel_ff <= '0;
        end else if (wr) begin
            if (PADDR_IN == 14'h1014)
                ea_ff <= (ea_ff & ~bm) | (PWDATA_IN & bm);
            if (PADDR_IN == 14'h1018)
                eb_ff <= (eb_ff & ~bm) | (PWDATA_IN & bm);
            if (PADDR_IN == 14'h1044)
                sel_ff <= (sel_ff & ~bm) | (PWDATA_IN & bm);
        end
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    AST_PAGE_FULL: assert property (
        q && ea_ff[17] && |(PAGE_FILLED_IN & sel_ff[15:0]) |-> ##2 IRQ_OUT)
        else $error("page full did not interrupt");
    AST_TRIG_STOP: assert property (
        q && ea_ff[16] && TRIG_STOP_IN |-> ##2 IRQ_OUT)
        else $error("trigger stop did not interrupt");
    AST_SAMPLE: assert property (
        q && ea_ff[15] && SAMPLE_READY_IN |-> ##2 IRQ_OUT)
        else $error("sample ready did not interrupt");
    AST_PULSE: assert property (
        |($past(PULSE_OUT_PIN_IN) & ~PULSE_OUT_PIN_IN & ea_ff[14:11])
        |-> ##[5:7] IRQ_OUT) else $error("pulse issue did not interrupt");
    AST_POWER_SIGN: assert property (
        q && |({REACTIVE_SIGN_CHG_IN, ACTIVE_SIGN_CHG_IN} & ea_ff[6:1])
        |-> ##2 IRQ_OUT) else $error("power sign did not interrupt");
    AST_ENERGY: assert property (
        q && ea_ff[0] && ENERGY_UPDATE_IN |-> ##2 IRQ_OUT)
        else $error("energy update did not interrupt");
    AST_FAULT_MASKED: assert property (
        q && |(FAULT_IN[3:2] & eb_ff[31:30]) |-> ##2 IRQ_OUT)
        else $error("enabled fault did not interrupt");
    AST_FAULT_NOMASK: assert property (
        |FAULT_IN[1:0] |-> ##2 IRQ_OUT)
        else $error("unmaskable fault did not interrupt");
    AST_CHECKSUM: assert property (
        q && (CHECKSUM_DONE_IN && eb_ff[27]
              || CHECKSUM_CHANGED_IN && eb_ff[26])
        |-> ##2 IRQ_OUT) else $error("checksum event did not interrupt");
    AST_SAG: assert property (
        q && |(~$past(SAG_LEVEL_IN) & SAG_LEVEL_IN & eb_ff[25:24])
        |-> ##[2:3] IRQ_OUT) else $error("dip entry did not interrupt");
    AST_QUIET_RESET: assert property (
        $past(RESET_IN) |-> !IRQ_OUT) else $error("request high after reset");
    cover property (|FAULT_IN[1:0] ##2 IRQ_OUT);
    cover property (|($past(PULSE_OUT_PIN_IN) & ~PULSE_OUT_PIN_IN));
    cover property (IRQ_OUT ##1 !IRQ_OUT);
endmodule : metirq_bank_props

bind metirq_bank metirq_bank_props #(.AW(AW)) metirq_bank_props_inst (.*);

// ===== metering_irq_mask_bank_bench.sv
`timescale 1ns/10ps
module metering_irq_mask_bank_bench;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, e, nm, irq;
    logic        rdy, err, trg = 0, smp = 0, egy = 0, cdn = 0, cch = 0;
    logic [13:0] pa = '0, w, s;
    logic [31:0] pd = '0, ck = '0, q, x, en, wm, prd, d;
    logic [15:0] pg = '0, sel;
    logic [3:0]  pin = 4'hf, sgn = '0, flt = '0, st = 4'hf, r;
    logic [2:0]  act = '0, rct = '0;
    logic [1:0]  sag = '0;
    int          fails = 0, total_checks = 0;
    always #2 clk = ~clk;
    metirq_bank metirq_bank_inst (
        .CLK_SYS_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd), .PSTRB_IN(st),
        .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
        .PAGE_FILLED_IN(pg), .TRIG_STOP_IN(trg), .SAMPLE_READY_IN(smp),
        .PULSE_OUT_PIN_IN(pin), .PULSE_SIGN_IN(sgn), .ACTIVE_SIGN_CHG_IN(act),
        .REACTIVE_SIGN_CHG_IN(rct), .ENERGY_UPDATE_IN(egy), .FAULT_IN(flt),
        .CHECKSUM_DONE_IN(cdn), .CHECKSUM_CHANGED_IN(cch),
        .CHECKSUM_VALUE_IN(ck), .SAG_LEVEL_IN(sag), .IRQ_OUT(irq));
    task stop_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // hold the whole request until ready is seen at an edge
    task apb(input logic wr_en, input logic [13:0] a, input logic [31:0] dat,
             input logic [3:0] sb);
        int n;
        @(posedge clk);
        psel <= 1;
        pw <= wr_en;
        pa <= a;
        pd <= dat;
        st <= sb;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        q = prd;
        e = err;
        psel <= 0;
        pen <= 0;
        if (n >= 20) begin
            fails++;
            stop_test();
        end
    endtask : apb
    task wr(input logic [13:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat, 4'hf);
    endtask : wr
    task rc(input logic [13:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0, 4'hf);
        chk(q, exp);
    endtask : rc
    task pulse(input logic [3:0] m, input logic [3:0] sg);
        sgn <= sg;
        pin <= ~m;
        cyc(4);
        pin <= 4'hf;
        cyc(4);
    endtask : pulse
    task fire(input int i);
        x = 32'h1 << i;
        @(posedge clk);
        if (i == 0) egy <= 1;
        else if (i < 4) act <= 3'h1 << (i - 1);
        else if (i < 7) rct <= 3'h1 << (i - 4);
        else if (i < 11) begin
            x = x | (32'h1 << (i + 4));
            pulse(4'h1 << (i - 7), 4'hf);
            pulse(4'h1 << (i - 7), 4'h0);
        end else if (i < 15) pulse(4'h1 << (i - 11), 4'h0);
        else if (i == 15) smp <= 1;
        else if (i == 16) trg <= 1;
        else if (i == 17) begin
            d = $urandom;
            pg <= d[15:0];
            if ((d[15:0] & sel) == 16'h0) x = '0;
        end else if (i < 26) sag <= 2'h1 << (i - 24);
        else if (i < 28) begin
            ck <= $urandom;
            cch <= (i == 26);
            cdn <= (i == 27);
        end else flt <= 4'h1 << (i - 28);
        @(posedge clk);
        {egy, act, rct, smp, trg, pg, sag, cch, cdn, flt} <= '0;
        cyc(8);
    endtask : fire
    initial begin
        void'($urandom(82));
        cyc(8);
        rst <= 0;
        chk({31'h0, irq}, 32'h0);
        rc(14'h1014, 32'h0);
        rc(14'h1018, 32'h0);
        chk({31'h0, e}, 32'h0);
        apb(1'b0, 14'h1000, '0, 4'hf);
        chk({31'h0, e}, 32'h1);
        // misaligned word address is refused like an unmapped one
        apb(1'b0, 14'h1016, '0, 4'hf);
        chk({31'h0, e}, 32'h1);
        wr(14'h1040, 32'hffffffff);
        rc(14'h1040, 32'h0);
        d = $urandom;
        apb(1'b1, 14'h1014, d, 4'h5);
        rc(14'h1014, d & 32'h00ff00ff & metirq_pkg::ENA_A_WMASK);
        wr(14'h1014, 32'h0);
        sel = 16'($urandom);
        wr(14'h1044, {16'h0, sel});
        rc(14'h1044, {16'h0, sel});
        for (int i = 0; i < 32; i++) begin
            if (i > 17 && i < 24) continue;
            w = (i >= 24) ? 14'h1018 : 14'h1014;
            s = w - 14'hc;
            wm = (i >= 24) ? metirq_pkg::ENA_B_WMASK : metirq_pkg::ENA_A_WMASK;
            nm = (i == 28 || i == 29);
            // first with every enable off: only unmaskable faults may show
            fire(i);
            chk({31'h0, irq}, {31'h0, nm});
            en = $urandom | (32'h1 << i);
            wr(w, en);
            cyc(2);
            chk({31'h0, irq}, {31'h0, |(x & en & wm) | nm});
            rc(w, en & wm);
            rc(s, x);
            if (i == 26 || i == 27) rc(14'h1048, ck);
            wr(s, 32'hffffffff);
            rc(s, x & 32'hb0000000);
            fire(i);
            chk({31'h0, irq}, {31'h0, |(x & en & wm) | nm});
            wr(14'h104c, 32'h1);
            wr(s, 32'hffffffff);
            wr(w, 32'h0);
            cyc(3);
            chk({31'h0, irq}, 32'h0);
            rc(s, 32'h0);
        end
        // every channel last pulsed negative, so a positive one flips sign
        r = 4'($urandom);
        wr(14'h1014, 32'h7800);
        pulse(4'hf, r);
        cyc(2);
        rc(14'h1040, {28'h0, r});
        rc(14'h1008, {17'h0, 4'hf, r, 7'h0});
        chk({31'h0, irq}, 32'h1);
        stop_test();
    end
endmodule : metering_irq_mask_bank_bench
